// ### src/orient_pkg.sv
// Package with constants, types and register map of the orientation classifier.
`default_nettype none
package orient_pkg;
  // ==========================================================================
  // Register map
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] HYST_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] MASK_OFS = 4'hC;
  // ==========================================================================
  // Field positions
  localparam int MODE_LSB = 0;
  localparam int FACE_EN_BIT = 2;
  localparam int FLAT_EN_BIT = 3;
  localparam int RANGE_LSB = 4;
  localparam int EVT_BIT = 0;
  localparam int CODE_LSB = 4;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] HYST_RST = 8'h00;
  localparam logic [2:0] CODE_RST = 3'h3;
  // Face hysteresis in 12-bit 2g units, halved for every range step.
  localparam logic [11:0] FACE_HYST_2G = 12'd205;
  // ==========================================================================
  // Modes and carriers
  typedef enum logic [1:0] {
    MODE_SYM = 2'b00,
    MODE_HIGH = 2'b01,
    MODE_LOW = 2'b10,
    MODE_SYM2 = 2'b11
  } mode_e;
  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } sample_s;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;
endpackage : orient_pkg
`default_nettype wire

// ### src/orientation_classifier.sv
// Orientation classifier: portrait/landscape and face up/down with hysteresis.
// Functional notes
// - Mode selector 00 or 11 is symmetrical, 01 high-asymmetrical and 10 low-asymmetrical.
// - The low two code bits are 00 landscape left, 01 landscape right, 10 portrait upside down, 11 upright.
// - Symmetrical mode splits at ratio 1, left or right by the sign of x, upside down or upright by the sign of y.
// - High-asymmetrical mode splits at ratio 2 with the same sign choices.
// - Low-asymmetrical mode splits at ratio 0.5 with the same sign choices.
// - Classification works on samples cut to their upper 8 bits.
// - Code bit 2 is 0 for face up when z is above the face hysteresis and 1 for face down when z is below its negative, else it holds.
// - The face bit is also computed while the flat enable is set.
// - The face contribution to the interrupt has its own enable bit.
// - Both decisions use hysteresis, the portrait/landscape one programmable for every condition.
// - Symmetrical landscape needs |y| below |x| minus hysteresis, portrait |y| above |x| plus hysteresis.
// - The three-bit code is readable in a field of the status register.
// - Every change of the code by a sample raises an event, bit 2 counting only with face enable, else reading 0.
// - High-asymmetrical landscape needs |y| below 2(|x|-h), portrait |y| above 2|x|+h.
// - Low-asymmetrical landscape needs |y| below (|x|-h)/2, portrait |y| above |x|/2+h.
// - Face hysteresis is 205 counts at 2g in 12-bit scale and halves for each wider range.
`default_nettype none
module orientation_classifier (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Samples
  input wire logic sample_valid_i,
  input wire orient_pkg::sample_s sample_i,
  // Register port
  input wire orient_pkg::bus_req_s bus_i,
  output logic [31:0] rdata_o,
  // Results
  output logic [2:0] orient_code_o,
  output logic irq_o
);
  // ==========================================================================
  // Registers
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] hyst_q, hyst_d;
  logic [0:0] stat_q, stat_d;
  logic [0:0] mask_q, mask_d;
  logic [1:0] pl_q, pl_d;
  logic face_q, face_d;
  logic [31:0] rdata_q, rdata_d;
  orient_pkg::mode_e mode;
  logic face_en, flat_en, face_calc;
  logic [1:0] range_sel;
  // ==========================================================================
  // Datapath
  logic signed [7:0] x8, y8, z8;
  logic [10:0] ax, ay, hy;
  logic signed [12:0] z12, fh;
  logic [11:0] fh_u;
  logic land, port, face_up_c, face_dn_c;
  logic [2:0] code_now, code_new;
  logic evt;

  assign face_en = ctrl_q[orient_pkg::FACE_EN_BIT];
  assign flat_en = ctrl_q[orient_pkg::FLAT_EN_BIT];
  assign range_sel = ctrl_q[orient_pkg::RANGE_LSB +: 2];
  assign face_calc = face_en | flat_en;

  always_comb begin
    x8 = sample_i.x[15:8];
    y8 = sample_i.y[15:8];
    z8 = sample_i.z[15:8];
    ax = x8[7] ? 11'(-12'(x8)) : 11'(x8);
    ay = y8[7] ? 11'(-12'(y8)) : 11'(y8);
    hy = 11'(hyst_q);
    unique case (ctrl_q[orient_pkg::MODE_LSB +: 2])
      2'b01: mode = orient_pkg::MODE_HIGH;
      2'b10: mode = orient_pkg::MODE_LOW;
      2'b11: mode = orient_pkg::MODE_SYM2;
      default: mode = orient_pkg::MODE_SYM;
    endcase
    // Conditions are rearranged to stay in integers: no divide and no rounding loss.
    unique case (mode)
      orient_pkg::MODE_HIGH: begin
        land = (ay + (hy << 1)) < (ax << 1);
        port = ay > ((ax << 1) + hy);
      end
      orient_pkg::MODE_LOW: begin
        land = ((ay << 1) + hy) < ax;
        port = (ay << 1) > (ax + (hy << 1));
      end
      default: begin
        land = (ay + hy) < ax;
        port = ay > (ax + hy);
      end
    endcase
    fh_u = orient_pkg::FACE_HYST_2G >> range_sel;
    fh = 13'(fh_u);
    // Sign is carried into the top bit so a negative z compares below the band.
    z12 = {z8[7], z8, 4'h0};
    face_up_c = z12 > fh;
    face_dn_c = z12 < -fh;
  end

  // ==========================================================================
  // Decision state
  always_comb begin
    pl_d = pl_q;
    face_d = face_q;
    if (ce_i && sample_valid_i) begin
      if (land) begin
        pl_d = {1'b0, x8[7]};
      end else if (port) begin
        pl_d = {1'b1, ~y8[7]};
      end
      if (face_calc && face_up_c) begin
        face_d = 1'b0;
      end else if (face_calc && face_dn_c) begin
        face_d = 1'b1;
      end
    end
  end

  // Bit 2 is masked rather than cleared so re-enabling restores the held face state.
  assign code_now = {face_en & face_q, pl_q};
  assign code_new = {face_en & face_d, pl_d};
  assign evt = code_new != code_now;
  assign orient_code_o = code_now;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pl_q <= orient_pkg::CODE_RST[1:0];
      face_q <= orient_pkg::CODE_RST[2];
    end else begin
      pl_q <= pl_d;
      face_q <= face_d;
    end
  end

  // ==========================================================================
  // Register port
  always_comb begin
    ctrl_d = ctrl_q;
    hyst_d = hyst_q;
    stat_d = stat_q;
    mask_d = mask_q;
    // Read data hold too while the enable is low.
    rdata_d = rdata_q;
    if (ce_i) begin
      rdata_d = 32'h0;
      if (bus_i.wr) begin
        unique case (bus_i.addr)
          orient_pkg::CTRL_OFS: ctrl_d = bus_i.wdata[7:0];
          orient_pkg::HYST_OFS: hyst_d = bus_i.wdata[7:0];
          orient_pkg::STATUS_OFS: stat_d = stat_q & ~bus_i.wdata[orient_pkg::EVT_BIT];
          orient_pkg::MASK_OFS: mask_d = bus_i.wdata[0:0];
          default: ;
        endcase
      end
      // A change in the same cycle as a clear stays pending.
      if (evt) begin
        stat_d = 1'b1;
      end
      if (bus_i.rd) begin
        unique case (bus_i.addr)
          orient_pkg::CTRL_OFS: rdata_d = {24'h0, ctrl_q};
          orient_pkg::HYST_OFS: rdata_d = {24'h0, hyst_q};
          orient_pkg::STATUS_OFS: rdata_d = {25'h0, code_now, 3'h0, stat_q};
          orient_pkg::MASK_OFS: rdata_d = {31'h0, mask_q};
          default: rdata_d = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_q <= orient_pkg::CTRL_RST;
      hyst_q <= orient_pkg::HYST_RST;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      hyst_q <= hyst_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
  assign irq_o = |(stat_q & mask_q);

  // ==========================================================================
  // Checks
  land_pick_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && sample_valid_i && land |=> pl_q == {1'b0, $past(x8[7])})
    else $error("landscape decision wrong");
  port_pick_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && sample_valid_i && !land && port |=> pl_q == {1'b1, ~$past(y8[7])})
    else $error("portrait decision wrong");
  sym_band_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && sample_valid_i && mode == orient_pkg::MODE_SYM && ay + hy < ax |=> !pl_q[1])
    else $error("symmetrical landscape missed");
  high_ratio_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && sample_valid_i && ctrl_q[1:0] == 2'b01 && ay > 2 * ax + hy |=> pl_q[1])
    else $error("high mode portrait missed");
  low_ratio_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && sample_valid_i && ctrl_q[1:0] == 2'b10 && 2 * ay + hy < ax |=> !pl_q[1])
    else $error("low mode landscape missed");
  band_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && sample_valid_i && !land && !port |=> $stable(pl_q))
    else $error("decision moved inside band");
  face_down_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && sample_valid_i && face_calc && face_dn_c |=> face_q)
    else $error("face down missed");
  face_up_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && sample_valid_i && face_calc && face_up_c |=> !face_q)
    else $error("face up missed");
  enable_freeze_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !ce_i |=> $stable(pl_q) && $stable(face_q) && $stable(ctrl_q) && $stable(rdata_o))
    else $error("state moved while disabled");
  face_mask_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !face_en |-> !orient_code_o[2])
    else $error("face bit shown while disabled");
  change_evt_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && orient_code_o != $past(orient_code_o) && $past(ctrl_q) == ctrl_q |-> stat_q)
    else $error("change without event");
  irq_level_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    stat_q && mask_q |-> irq_o ##1 (irq_o || !stat_q || !mask_q))
    else $error("interrupt not raised");
  code_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && bus_i.rd && bus_i.addr == orient_pkg::STATUS_OFS |=> rdata_o[6:4] == $past(orient_code_o))
    else $error("status code read wrong");
endmodule : orientation_classifier
`default_nettype wire

// ### sim/sample_source.sv
// Model of the accelerometer sample path that feeds the classifier.
`default_nettype none
// ==========================================================================
// Sample source
module sample_source (
  // Clock
  input wire logic clock_i,
  // Bench control
  input wire logic go_i,
  input wire logic [23:0] xyz_i,
  // Sample stream
  output logic sample_valid_o,
  output orient_pkg::sample_s sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] noise_q = 8'hA5;
  // The low bytes churn every cycle, so a design that reads them cannot match by luck.
  always @(posedge clock_i) begin
    noise_q <= noise_q + 8'h3B;
    sample_valid_o <= go_i;
    sample_o <= {xyz_i[23:16], noise_q, xyz_i[15:8], ~noise_q, xyz_i[7:0], noise_q ^ 8'h5A};
  end
endmodule : sample_source
`default_nettype wire

// ### sim/tb_orientation_classifier.sv
// Self-checking bench of the orientation classifier.
`default_nettype none
// ==========================================================================
// Bench
module tb_orientation_classifier;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic go = 1'b0;
  logic ce = 1'b1;
  logic [23:0] xyz = 24'h0;
  logic sample_valid;
  orient_pkg::sample_s sample;
  orient_pkg::bus_req_s bus = '0;
  logic [31:0] rdata;
  logic [2:0] code;
  logic irq;
  int n_fail = 0;
  int checked = 0;
  // Rows: mode nibble, x, y, z bytes, expected code nibble.
  logic [31:0] rows [8] = '{32'h0_40_10_40_0, 32'h0_C0_10_C0_5, 32'h0_10_C0_40_2, 32'h3_10_40_40_3,
                            32'h1_20_30_40_0, 32'h1_10_30_40_3, 32'h2_40_D0_40_2, 32'h2_40_10_40_0};
  always #5 clock_i = ~clock_i;
  sample_source model (.clock_i(clock_i), .go_i(go), .xyz_i(xyz), .sample_valid_o(sample_valid),
                       .sample_o(sample));
  orientation_classifier DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce), .sample_valid_i(sample_valid),
                              .sample_i(sample), .bus_i(bus), .rdata_o(rdata), .orient_code_o(code), .irq_o(irq));
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus <= '0;
    #1;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask : rd
  task automatic send(input logic [23:0] v, input logic [2:0] exp);
    @(posedge clock_i);
    go <= 1'b1;
    xyz <= v;
    @(posedge clock_i);
    go <= 1'b0;
    @(posedge clock_i);
    #1;
    chk({29'h0, code}, {29'h0, exp});
  endtask : send
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  // ==========================================================================
  // Watchdog
  initial begin
    #50000;
    n_fail++;
    stop_test();
  end
  // ==========================================================================
  // Tests
  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1;
    chk({29'h0, code}, 32'h3);
    chk({31'h0, irq}, 32'h0);
    rd(orient_pkg::CTRL_OFS, 32'h0);
    rd(orient_pkg::STATUS_OFS, 32'h30);
    rd(4'h2, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(orient_pkg::CTRL_OFS, {28'h0, rows[i][31:28]} | 32'h4);
      send(rows[i][27:4], rows[i][2:0]);
    end
    $display("test table done");
    wr(orient_pkg::HYST_OFS, 32'h8);
    wr(orient_pkg::CTRL_OFS, 32'h4);
    send(24'h40_10_40, 3'h0);
    send(24'h40_3C_40, 3'h0);
    send(24'h40_44_40, 3'h0);
    send(24'h40_4A_40, 3'h3);
    send(24'h40_10_C0, 3'h4);
    send(24'h40_10_0C, 3'h4);
    send(24'h40_10_10, 3'h0);
    $display("test hysteresis done");
    wr(orient_pkg::MASK_OFS, 32'h1);
    wr(orient_pkg::STATUS_OFS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    send(24'h40_10_C0, 3'h4);
    chk({31'h0, irq}, 32'h1);
    rd(orient_pkg::STATUS_OFS, 32'h41);
    wr(orient_pkg::MASK_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(orient_pkg::MASK_OFS, 32'h1);
    wr(orient_pkg::STATUS_OFS, 32'h1);
    send(24'h40_10_C0, 3'h4);
    chk({31'h0, irq}, 32'h0);
    wr(orient_pkg::CTRL_OFS, 32'h0);
    wr(orient_pkg::STATUS_OFS, 32'h1);
    send(24'h40_10_40, 3'h0);
    chk({31'h0, irq}, 32'h0);
    rd(orient_pkg::STATUS_OFS, 32'h0);
    $display("test interrupt done");
    wr(orient_pkg::CTRL_OFS, 32'h8);
    send(24'h40_10_40, 3'h0);
    wr(orient_pkg::CTRL_OFS, 32'h4);
    chk({29'h0, code}, 32'h0);
    wr(orient_pkg::CTRL_OFS, 32'h34);
    send(24'h40_10_FE, 3'h4);
    @(posedge clock_i);
    ce <= 1'b0;
    send(24'h10_40_40, 3'h4);
    @(posedge clock_i);
    ce <= 1'b1;
    send(24'h10_40_40, 3'h3);
    $display("test enable and range done");
    stop_test();
  end
endmodule : tb_orientation_classifier
`default_nettype wire
